/* hdl/backlight_boost_config_bank.sv */
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "boost_cfg_map.svh"

module backlight_boost_config_bank #(
	parameter int MS_CYC = `CLK_HZ / `MS_PER_S
) (
	input  wire logic                    CLK,
	input  wire logic                    RST,
	input  wire logic                    CE,
	input  wire boost_cfg_pkg::apb_req_t APB_REQ,
	output      boost_cfg_pkg::apb_rsp_t APB_RSP,
	output      logic                    NVM_RD_REQ,
	output      logic [7:0]              NVM_RD_ADDR,
	input  wire logic                    NVM_RD_VALID,
	input  wire logic [7:0]              NVM_RD_DATA,
	input  wire logic                    BACKLIGHT_ON,
	input  wire logic [7:0]              BRIGHT_TARGET,
	input  wire logic                    PWM_CYCLE_TICK,
	input  wire logic [7:0]              STRING_VF_MAX,
	input  wire logic [2:0]              SINK_HEADROOM_SEL,
	input  wire logic [7:0]              FIXED_OUTPUT_LEVEL,
	input  wire logic [7:0]              STARTUP_LEVEL,
	input  wire logic                    START_LEVEL_OK,
	output      logic                    CONFIG_VALID,
	output      logic [1:0]              SWITCH_RATE_SEL,
	output      logic [10:0]             SWITCH_RATE_KHZ,
	output      logic                    STRING_FAULT_DETECT_ON,
	output      logic                    DERATE_ON,
	output      logic [7:0]              DERATE_TEMP_C,
	output      logic [11:0]             COIL_CURRENT_LIMIT_MA,
	output      logic                    CONV_ENABLE,
	output      logic                    INT_SWITCH_EN,
	output      logic                    GATE_DRIVE_PIN_EN,
	output      logic [7:0]              BRIGHT_LEVEL,
	output      logic [7:0]              OUTPUT_LEVEL_REQ
);
	import boost_cfg_pkg::*;

	localparam logic [11:0] ADDR_RAMP   = 12'(`IDX_RAMP_CFG << 2);
	localparam logic [11:0] ADDR_TRACK  = 12'(`IDX_TRACK_CFG << 2);
	localparam logic [11:0] ADDR_STATUS = 12'(`IDX_STATUS << 2);

	ramp_cfg_t   ramp_cfg_ff;
	track_cfg_t  track_cfg_ff;
	load_st_t    load_st_ff;
	logic        load_second_ff;
	logic [31:0] prdata_ff;
	logic        start_meta_ff;
	logic        start_ok_ff;
	logic        track_phase_ff;
	logic [3:0]  upd_cnt_ff;
	logic [7:0]  level_req_ff;
	logic [7:0]  bright_ff;
	logic [23:0] ramp_cnt_ff;
	logic        loaded;
	logic        setup;
	logic        access;
	logic        hit;
	logic        wr;
	logic        upd;
	logic [9:0]  ramp_ms;
	logic [23:0] step_len;
	logic [7:0]  diff;
	logic [8:0]  track_sum;
	logic [7:0]  track_tgt;
	logic        conv_on;

	assign loaded = (load_st_ff == ST_DONE);
	assign setup  = APB_REQ.psel && !APB_REQ.penable;
	assign access = APB_REQ.psel && APB_REQ.penable;
	assign hit    = (APB_REQ.paddr == ADDR_RAMP) || (APB_REQ.paddr == ADDR_TRACK)
		|| (APB_REQ.paddr == ADDR_STATUS);
	// Stalls the bus while the power-up load is still running
	assign APB_RSP.pready  = loaded && CE;
	assign APB_RSP.pslverr = access && !hit;
	assign APB_RSP.prdata  = prdata_ff;
	assign wr = access && APB_REQ.pwrite && loaded && CE;

	always_ff @(posedge CLK) begin
		if (RST) begin
			load_st_ff     <= ST_IDLE;
			load_second_ff <= 1'b0;
			NVM_RD_REQ     <= 1'b0;
			NVM_RD_ADDR    <= 8'h00;
		end else if (CE) begin
			case (load_st_ff)
				ST_IDLE: begin
					load_st_ff <= ST_REQ;
				end
				ST_REQ: begin
					NVM_RD_REQ  <= 1'b1;
					NVM_RD_ADDR <= load_second_ff ? `NVM_ADDR_TRACK : `NVM_ADDR_RAMP;
					load_st_ff  <= ST_WAIT;
				end
				ST_WAIT: begin
					if (NVM_RD_VALID) begin
						NVM_RD_REQ     <= 1'b0;
						load_second_ff <= 1'b1;
						load_st_ff     <= load_second_ff ? ST_DONE : ST_REQ;
					end
				end
				ST_DONE: begin
					load_st_ff <= ST_DONE;
				end
				default: begin
					load_st_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Configuration bytes: NVM load first, then bus writes
	always_ff @(posedge CLK) begin
		if (RST) begin
			ramp_cfg_ff  <= `RST_RAMP_CFG;
			track_cfg_ff <= `RST_TRACK_CFG;
		end else if (CE) begin
			if (load_st_ff == ST_WAIT && NVM_RD_VALID) begin
				if (load_second_ff) begin
					track_cfg_ff <= NVM_RD_DATA;
				end else begin
					ramp_cfg_ff <= NVM_RD_DATA;
				end
			end
			if (wr && APB_REQ.paddr == ADDR_RAMP) begin
				ramp_cfg_ff <= APB_REQ.pwdata[7:0];
			end
			if (wr && APB_REQ.paddr == ADDR_TRACK) begin
				track_cfg_ff <= APB_REQ.pwdata[7:0];
			end
		end
	end

	// Read data captured in setup so the access phase needs no wait
	always_ff @(posedge CLK) begin
		if (RST) begin
			prdata_ff <= 32'h0000_0000;
		end else if (CE && setup) begin
			case (APB_REQ.paddr)
				ADDR_RAMP:   prdata_ff <= {24'h00_0000, ramp_cfg_ff};
				ADDR_TRACK:  prdata_ff <= {24'h00_0000, track_cfg_ff};
				ADDR_STATUS: prdata_ff <= {8'h00, level_req_ff, bright_ff, 6'h00, track_phase_ff, loaded};
				default:     prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// Converter runs only after load and while the backlight is on
	assign conv_on = loaded && track_cfg_ff.conv_auto_on && BACKLIGHT_ON;

	always_ff @(posedge CLK) begin
		if (RST) begin
			CONFIG_VALID <= 1'b0;
		end else if (CE) begin
			CONFIG_VALID <= loaded;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			SWITCH_RATE_SEL <= 2'b00;
			SWITCH_RATE_KHZ <= 11'h09C;
		end else if (CE) begin
			SWITCH_RATE_SEL <= ramp_cfg_ff.switch_rate_sel;
			case (ramp_cfg_ff.switch_rate_sel)
				2'b00:   SWITCH_RATE_KHZ <= 11'h09C;
				2'b01:   SWITCH_RATE_KHZ <= 11'h138;
				2'b10:   SWITCH_RATE_KHZ <= 11'h271;
				default: SWITCH_RATE_KHZ <= 11'h4E2;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			STRING_FAULT_DETECT_ON <= 1'b0;
		end else if (CE) begin
			STRING_FAULT_DETECT_ON <= loaded && ramp_cfg_ff.string_fault_detect_on;
		end
	end

	// derating threshold
	// First byte lands before the second; hold derating off until both are in
	always_ff @(posedge CLK) begin
		if (RST) begin
			DERATE_ON     <= 1'b0;
			DERATE_TEMP_C <= 8'h00;
		end else if (CE) begin
			DERATE_ON <= loaded && (ramp_cfg_ff.thermal_derate_threshold != 2'b00);
			case (loaded ? ramp_cfg_ff.thermal_derate_threshold : 2'b00)
				2'b01:   DERATE_TEMP_C <= 8'h6E;
				2'b10:   DERATE_TEMP_C <= 8'h78;
				2'b11:   DERATE_TEMP_C <= 8'h82;
				default: DERATE_TEMP_C <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			COIL_CURRENT_LIMIT_MA <= 12'h384;
		end else if (CE) begin
			case (track_cfg_ff.coil_current_limit)
				2'b00:   COIL_CURRENT_LIMIT_MA <= 12'h384;
				2'b01:   COIL_CURRENT_LIMIT_MA <= 12'h578;
				2'b10:   COIL_CURRENT_LIMIT_MA <= 12'h7D0;
				default: COIL_CURRENT_LIMIT_MA <= 12'h9C4;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			CONV_ENABLE <= 1'b0;
		end else if (CE) begin
			CONV_ENABLE <= conv_on;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			INT_SWITCH_EN     <= 1'b0;
			GATE_DRIVE_PIN_EN <= 1'b0;
		end else if (CE) begin
			INT_SWITCH_EN     <= conv_on && !track_cfg_ff.outside_switch_sel;
			GATE_DRIVE_PIN_EN <= conv_on && track_cfg_ff.outside_switch_sel;
		end
	end

	// Ramp length in ms per full-scale swing
	always_comb begin
		case (ramp_cfg_ff.ramp_sel)
			3'b001:  ramp_ms = 10'h032;
			3'b010:  ramp_ms = 10'h04B;
			3'b011:  ramp_ms = 10'h064;
			3'b100:  ramp_ms = 10'h096;
			3'b101:  ramp_ms = 10'h0C8;
			3'b110:  ramp_ms = 10'h12C;
			3'b111:  ramp_ms = 10'h1F4;
			default: ramp_ms = 10'h000;
		endcase
	end

	// One level step per slice; a full swing takes the selected time
	assign step_len = 24'((32'(ramp_ms) * 32'(MS_CYC)) / `RAMP_STEPS);
	assign diff = (BRIGHT_TARGET > bright_ff) ? (BRIGHT_TARGET - bright_ff) : (bright_ff - BRIGHT_TARGET);

	always_ff @(posedge CLK) begin
		if (RST) begin
			bright_ff   <= 8'h00;
			ramp_cnt_ff <= 24'h00_0000;
		end else if (CE) begin
			if (ramp_cfg_ff.ramp_sel == 3'b000) begin
				bright_ff   <= BRIGHT_TARGET;
				ramp_cnt_ff <= 24'h00_0000;
			end else if (bright_ff == BRIGHT_TARGET) begin
				ramp_cnt_ff <= 24'h00_0000;
			end else if (ramp_cnt_ff + 24'h00_0001 < ((track_cfg_ff.smooth_ramp_on && diff < `SMOOTH_ZONE)
				? (step_len << 1) : step_len)) begin
				ramp_cnt_ff <= ramp_cnt_ff + 24'h00_0001;
			end else begin
				ramp_cnt_ff <= 24'h00_0000;
				bright_ff   <= (BRIGHT_TARGET > bright_ff) ? bright_ff + 8'h01 : bright_ff - 8'h01;
			end
		end
	end

	assign BRIGHT_LEVEL = bright_ff;

	// Startup-reached flag comes from the analog side
	always_ff @(posedge CLK) begin
		if (RST) begin
			start_meta_ff <= 1'b0;
			start_ok_ff   <= 1'b0;
		end else if (CE) begin
			start_meta_ff <= START_LEVEL_OK;
			start_ok_ff   <= start_meta_ff;
		end
	end

	assign upd = PWM_CYCLE_TICK && (!track_cfg_ff.slow_update || upd_cnt_ff == 4'(`SLOW_UPD_DIV - 1));

	always_ff @(posedge CLK) begin
		if (RST) begin
			upd_cnt_ff <= 4'h0;
		end else if (CE && PWM_CYCLE_TICK) begin
			upd_cnt_ff <= upd_cnt_ff + 4'h1;
		end
	end

	// Headroom in level units, one unit per headroom step plus one
	assign track_sum = {1'b0, STRING_VF_MAX} + {5'h00, SINK_HEADROOM_SEL} + 9'h001;
	assign track_tgt = track_sum[8] ? 8'hFF : track_sum[7:0];

	always_ff @(posedge CLK) begin
		if (RST) begin
			track_phase_ff <= 1'b0;
			level_req_ff   <= 8'h00;
		end else if (CE) begin
			if (!track_cfg_ff.adapt_on) begin
				track_phase_ff <= 1'b0;
				level_req_ff   <= FIXED_OUTPUT_LEVEL;
			end else if (!conv_on || !track_phase_ff) begin
				level_req_ff   <= STARTUP_LEVEL;
				track_phase_ff <= conv_on && start_ok_ff;
			end else if (upd) begin
				if (track_tgt > level_req_ff) begin
					level_req_ff <= track_cfg_ff.alt_track ? track_tgt : level_req_ff + 8'h01;
				end else if (track_tgt < level_req_ff) begin
					level_req_ff <= level_req_ff - 8'h01;
				end
			end
		end
	end

	assign OUTPUT_LEVEL_REQ = level_req_ff;

endmodule // backlight_boost_config_bank

/* hdl/boost_cfg_map.svh */
`ifndef BOOST_CFG_MAP_SVH
`define BOOST_CFG_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_RAMP_CFG    12'h0A1
`define IDX_TRACK_CFG   12'h0A2
`define IDX_STATUS      12'h0C0

// Non-volatile source addresses of the two bytes
`define NVM_ADDR_RAMP   8'hA1
`define NVM_ADDR_TRACK  8'hA2

// Reset values before the power-up load
`define RST_RAMP_CFG    8'h00
`define RST_TRACK_CFG   8'h00

// Field positions, first byte
`define F_RATE_HI       7
`define F_RATE_LO       6
`define F_FAULT         5
`define F_DERATE_HI     4
`define F_DERATE_LO     3
`define F_RAMP_HI       2
`define F_RAMP_LO       0

// Field positions, second byte
`define F_ALT_TRACK     7
`define F_SLOW_UPD      6
`define F_SMOOTH        5
`define F_OUTSIDE_SW    4
`define F_ADAPT         3
`define F_CONV_EN       2
`define F_ILIM_HI       1
`define F_ILIM_LO       0

// Timing
`define CLK_HZ          10000000
`define MS_PER_S        1000
`define RAMP_STEPS      256
`define SLOW_UPD_DIV    16
`define SMOOTH_ZONE     8'h10

`endif

/* hdl/boost_cfg_pkg.sv */
package boost_cfg_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQ  = 2'b01,
		ST_WAIT = 2'b10,
		ST_DONE = 2'b11
	} load_st_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic [1:0]  switch_rate_sel;
		logic        string_fault_detect_on;
		logic [1:0]  thermal_derate_threshold;
		logic [2:0]  ramp_sel;
	} ramp_cfg_t;

	typedef struct packed {
		logic        alt_track;
		logic        slow_update;
		logic        smooth_ramp_on;
		logic        outside_switch_sel;
		logic        adapt_on;
		logic        conv_auto_on;
		logic [1:0]  coil_current_limit;
	} track_cfg_t;

endpackage

/* tb/boost_cfg_asserts.sv */
`timescale 1ns/1ps
module boost_cfg_asserts (
	input wire logic                    CLK,
	input wire logic                    RST,
	input wire logic                    CE,
	input wire boost_cfg_pkg::apb_req_t APB_REQ,
	input wire boost_cfg_pkg::apb_rsp_t APB_RSP,
	input wire logic                    NVM_RD_REQ,
	input wire logic [7:0]              NVM_RD_ADDR,
	input wire logic                    NVM_RD_VALID,
	input wire logic                    BACKLIGHT_ON,
	input wire logic                    CONFIG_VALID,
	input wire logic [1:0]              SWITCH_RATE_SEL,
	input wire logic [10:0]             SWITCH_RATE_KHZ,
	input wire logic                    STRING_FAULT_DETECT_ON,
	input wire logic                    DERATE_ON,
	input wire logic [7:0]              DERATE_TEMP_C,
	input wire logic [11:0]             COIL_CURRENT_LIMIT_MA,
	input wire logic                    CONV_ENABLE,
	input wire logic                    INT_SWITCH_EN,
	input wire logic                    GATE_DRIVE_PIN_EN
);
	import boost_cfg_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic wr;
	assign wr = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready & APB_REQ.pwrite;
	function automatic logic [11:0] ilim(input logic [1:0] c);
		return c[1] ? (c[0] ? 12'h9C4 : 12'h7D0) : (c[0] ? 12'h578 : 12'h384);
	endfunction
	rate_decode_a: assert property (SWITCH_RATE_KHZ == (SWITCH_RATE_SEL[1] ?
		(SWITCH_RATE_SEL[0] ? 11'h4E2 : 11'h271) : (SWITCH_RATE_SEL[0] ? 11'h138 : 11'h09C)))
		else $error("rate decode wrong");
	derate_decode_a: assert property (DERATE_ON == (DERATE_TEMP_C != 8'h00))
		else $error("derate flag wrong");
	switch_excl_a: assert property (!(INT_SWITCH_EN && GATE_DRIVE_PIN_EN))
		else $error("both switches on");
	conv_cause_a: assert property (CONV_ENABLE |-> $past(BACKLIGHT_ON))
		else $error("converter on without backlight");
	unmapped_err_a: assert property (APB_REQ.psel && APB_REQ.penable &&
		!(APB_REQ.paddr inside {12'h284, 12'h288, 12'h300}) |-> APB_RSP.pslverr)
		else $error("unmapped access not refused");
	load_order_a: assert property (NVM_RD_VALID && NVM_RD_REQ && NVM_RD_ADDR == 8'hA1
		|-> ##[1:4] (NVM_RD_REQ && NVM_RD_ADDR == 8'hA2)) else $error("second byte not fetched");
	ready_gate_a: assert property (CONFIG_VALID && CE |-> APB_RSP.pready)
		else $error("bus stalled after load");
	fault_write_a: assert property (wr && APB_REQ.paddr == 12'h284
		|-> ##2 STRING_FAULT_DETECT_ON == $past(APB_REQ.pwdata[5], 2)) else $error("fault bit not applied");
	ilim_write_a: assert property (wr && APB_REQ.paddr == 12'h288
		|-> ##2 COIL_CURRENT_LIMIT_MA == ilim($past(APB_REQ.pwdata[1:0], 2))) else $error("limit not applied");
	cover property (wr && APB_REQ.paddr == 12'h284);
	cover property (APB_RSP.pslverr);
	cover property ($rose(CONV_ENABLE));
endmodule // boost_cfg_asserts
bind backlight_boost_config_bank boost_cfg_asserts u_chk (.CLK(CLK), .RST(RST), .CE(CE),
	.APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .NVM_RD_REQ(NVM_RD_REQ), .NVM_RD_ADDR(NVM_RD_ADDR),
	.NVM_RD_VALID(NVM_RD_VALID), .BACKLIGHT_ON(BACKLIGHT_ON), .CONFIG_VALID(CONFIG_VALID),
	.SWITCH_RATE_SEL(SWITCH_RATE_SEL), .SWITCH_RATE_KHZ(SWITCH_RATE_KHZ),
	.STRING_FAULT_DETECT_ON(STRING_FAULT_DETECT_ON), .DERATE_ON(DERATE_ON),
	.DERATE_TEMP_C(DERATE_TEMP_C), .COIL_CURRENT_LIMIT_MA(COIL_CURRENT_LIMIT_MA),
	.CONV_ENABLE(CONV_ENABLE), .INT_SWITCH_EN(INT_SWITCH_EN), .GATE_DRIVE_PIN_EN(GATE_DRIVE_PIN_EN));

/* tb/backlight_boost_config_bank_bench.sv */
`timescale 1ns/1ps
module backlight_boost_config_bank_bench;
	import boost_cfg_pkg::*;
	logic       clk = 1'b0, rst = 1'b1, bl_on = 1'b1, tick = 1'b0, vld = 1'b0, nreq, er;
	logic       fdet, don, cen, ise, gde, cfv;
	logic       ce = 1'b1, sok = 1'b0;
	logic [7:0] vfm = 8'h40;
	logic [1:0] rsel;
	logic [7:0] tgt = 8'h10, nvd = 8'h00, nadr, dtc, blv, olv;
	logic [10:0] khz;
	logic [11:0] ima;
	logic [31:0] rd;
	apb_req_t   req = '0;
	apb_rsp_t   rsp;
	int         mismatches = 0, check_count = 0;
	logic [10:0] khz_tab [4] = '{11'h09C, 11'h138, 11'h271, 11'h4E2};
	logic [7:0]  tmp_tab [4] = '{8'h00, 8'h6E, 8'h78, 8'h82};
	logic [11:0] ma_tab [4] = '{12'h384, 12'h578, 12'h7D0, 12'h9C4};
	// Short ramp count so a 50 ms slope is seven cycles a step
	backlight_boost_config_bank #(.MS_CYC(40)) u_dut (.CLK(clk), .RST(rst), .CE(ce),
		.APB_REQ(req), .APB_RSP(rsp), .NVM_RD_REQ(nreq), .NVM_RD_ADDR(nadr), .NVM_RD_VALID(vld),
		.NVM_RD_DATA(nvd), .BACKLIGHT_ON(bl_on), .BRIGHT_TARGET(tgt), .PWM_CYCLE_TICK(tick),
		.STRING_VF_MAX(vfm), .SINK_HEADROOM_SEL(3'h2), .FIXED_OUTPUT_LEVEL(8'h77),
		.STARTUP_LEVEL(8'h30), .START_LEVEL_OK(sok), .CONFIG_VALID(cfv), .SWITCH_RATE_SEL(rsel),
		.SWITCH_RATE_KHZ(khz), .STRING_FAULT_DETECT_ON(fdet), .DERATE_ON(don), .DERATE_TEMP_C(dtc),
		.COIL_CURRENT_LIMIT_MA(ima), .CONV_ENABLE(cen), .INT_SWITCH_EN(ise),
		.GATE_DRIVE_PIN_EN(gde), .BRIGHT_LEVEL(blv), .OUTPUT_LEVEL_REQ(olv));
	always #50 clk = ~clk;
	// Memory answers one cycle after each request
	always @(posedge clk) begin
		vld <= nreq & ~vld;
		nvd <= (nadr == 8'hA1) ? 8'hB5 : 8'hAF;
		tick <= ~tick;
	end
	task chk(input logic [31:0] e, input logic [31:0] g, input string n);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		req <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		// Answer read once settled; the taking edge follows
		do begin
			@(negedge clk);
			rd = rsp.prdata;
			er = rsp.pslverr;
			n++;
		end while (rsp.pready !== 1'b1 && n < 100);
		@(posedge clk);
		if (n >= 100) mismatches++;
		req <= '0;
		repeat (3) @(negedge clk);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 50 && cfv !== 1'b1; i++) @(negedge clk);
		apb(1'b0, 12'h284, 32'h0);
		chk(32'hB5, rd, "ramp byte");
		apb(1'b0, 12'h288, 32'h0);
		chk(32'hAF, rd, "track byte");
		chk(32'(khz_tab[2]), 32'(khz), "loaded rate");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h284, {24'h0, i[1:0], i[0], i[1:0], 3'h0});
			chk(32'(khz_tab[i]), 32'(khz), "rate");
			chk(32'(i[0]), 32'(fdet), "fault detect");
			chk(32'(tmp_tab[i]), 32'(dtc), "derate");
			apb(1'b1, 12'h288, {24'h0, 3'h0, i[0], 2'b01, i[1:0]});
			chk(32'(ma_tab[i]), 32'(ima), "coil limit");
			chk(32'({i[0], ~i[0]}), 32'({gde, ise}), "switch");
			chk(32'h1, 32'(cen), "conv on");
			chk(32'h77, 32'(olv), "fixed level");
		end
		apb(1'b1, 12'h288, 32'h0);
		chk(32'h0, 32'(cen), "conv off");
		@(posedge clk);
		tgt <= 8'h5A;
		repeat (3) @(negedge clk);
		chk(32'h5A, 32'(blv), "no ramp");
		@(posedge clk);
		ce  <= 1'b0;
		tgt <= 8'h20;
		repeat (3) @(negedge clk);
		chk(32'h5A, 32'(blv), "frozen level");
		@(posedge clk);
		ce <= 1'b1;
		repeat (2) @(negedge clk);
		chk(32'h20, 32'(blv), "resumed level");
		@(posedge clk);
		tgt <= 8'h5A;
		repeat (2) @(negedge clk);
		apb(1'b1, 12'h284, 32'h1);
		@(posedge clk);
		tgt <= 8'h66;
		repeat (30) @(negedge clk);
		chk(32'h1, 32'(blv > 8'h5A && blv < 8'h66), "ramp midway");
		repeat (100) @(negedge clk);
		chk(32'h66, 32'(blv), "ramp end");
		apb(1'b1, 12'h288, 32'h20);
		@(posedge clk);
		tgt <= 8'h5A;
		// Plain slope would finish in 84 cycles
		repeat (100) @(negedge clk);
		chk(32'h1, 32'(blv != 8'h5A), "smooth slower");
		repeat (120) @(negedge clk);
		chk(32'h5A, 32'(blv), "smooth end");
		apb(1'b1, 12'h288, 32'h0C);
		chk(32'h30, 32'(olv), "startup level");
		@(posedge clk);
		sok <= 1'b1;
		repeat (60) @(negedge clk);
		chk(32'h43, 32'(olv), "track level");
		apb(1'b1, 12'h288, 32'h8C);
		@(posedge clk);
		vfm <= 8'h60;
		repeat (4) @(negedge clk);
		chk(32'h63, 32'(olv), "alt jump");
		apb(1'b1, 12'h288, 32'h4C);
		@(posedge clk);
		vfm <= 8'h50;
		// Twenty ticks give one or two slow updates
		repeat (40) @(negedge clk);
		chk(32'h1, 32'(olv > 8'h60 && olv < 8'h63), "slow update");
		@(posedge clk);
		bl_on <= 1'b0;
		repeat (3) @(negedge clk);
		chk(32'h0, 32'({cen, ise, gde}), "backlight off");
		chk(32'h30, 32'(olv), "restart level");
		apb(1'b0, 12'h100, 32'h0);
		chk(32'h1, 32'(er), "unmapped err");
		chk(32'h0, rd, "unmapped data");
		apb(1'b0, 12'h300, 32'h0);
		chk(32'h1, 32'(rd[0]), "load done");
		report_and_stop;
	end
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		report_and_stop;
	end
endmodule // backlight_boost_config_bank_bench
